// [logic/srbb_builder.v]
`timescale 1ns/1ps
`include "srbb_defines.vh"
// builds and streams the response block for each accepted command
module srbb_builder (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [4:0]  rotary_address_switch,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [1:0]  cmd_update_counter,
  input  wire [6:0]  cmd_code,
  input  wire        cmd_fault,
  input  wire [3:0]  cmd_ncyc_code,
  input  wire [31:0] ncyc_result_two,
  input  wire [31:0] ncyc_result_three,
  input  wire [7:0]  servo_flags,
  input  wire [7:0]  input_flags,
  output wire [7:0]  mon_type_one,
  output wire [7:0]  mon_type_two,
  output wire [7:0]  mon_type_three,
  input  wire [31:0] mon_value_one,
  input  wire [31:0] mon_value_two,
  input  wire [31:0] mon_value_three,
  output wire        resp_valid,
  input  wire        resp_ready,
  output wire [7:0]  resp_data,
  output wire        resp_last,
  output wire        irq
);

  // register file
  reg  [1:0]   ctrl_ff;
  reg  [23:0]  mon_sel_ff;
  reg  [1:0]   irq_status_ff;
  reg  [1:0]   irq_enable_ff;
  reg  [31:0]  blk_count_ff;

  // bus slave state
  reg          aw_got_ff;
  reg          w_got_ff;
  reg  [7:0]   awaddr_ff;
  reg  [31:0]  wdata_ff;
  reg  [3:0]   wstrb_ff;
  reg          bvalid_ff;
  reg  [1:0]   bresp_ff;
  reg          rvalid_ff;
  reg  [31:0]  rdata_ff;
  reg  [1:0]   rresp_ff;

  // node address capture
  wire [4:0]   switch_stable;
  reg  [2:0]   settle_ff;
  reg          addr_taken_ff;
  reg  [4:0]   node_addr_ff;

  // framing
  reg  [255:0] shift_ff;
  reg  [5:0]   idx_ff;
  reg  [5:0]   len_ff;
  reg          busy_ff;
  reg  [6:0]   last_code_ff;
  reg  [7:0]   type_one_ff;
  reg  [7:0]   type_two_ff;
  reg  [7:0]   type_three_ff;
  wire [7:0]   nxt_type_one;
  wire [7:0]   nxt_type_two;
  wire [7:0]   nxt_type_three;

  wire         wr_fire;
  wire         rd_fire;
  wire         cmd_fire;
  wire         byte_fire;
  wire         last_byte;
  reg  [31:0]  nxt_rdata;
  reg  [1:0]   nxt_rresp;
  reg  [31:0]  word_two;
  reg  [31:0]  word_three;
  wire [7:0]   hdr_byte0;
  wire [7:0]   hdr_byte1;
  wire [127:0] blk16;
  wire [1:0]   irq_events;
  wire [31:0]  wmask;

  // monitor type codes, zero selects the compatibility default
  srbb_mon_sel #(
    .DEFAULT_CODE (`SRBB_TYPE_POSITION)
  ) u_sel_one (
    .sel       (mon_sel_ff[7:0]),
    .type_code (nxt_type_one)
  );

  srbb_mon_sel #(
    .DEFAULT_CODE (`SRBB_TYPE_SPEED)
  ) u_sel_two (
    .sel       (mon_sel_ff[15:8]),
    .type_code (nxt_type_two)
  );

  srbb_mon_sel #(
    .DEFAULT_CODE (`SRBB_TYPE_TORQUE)
  ) u_sel_three (
    .sel       (mon_sel_ff[23:16]),
    .type_code (nxt_type_three)
  );

  srbb_sync3 #(
    .W (5)
  ) u_switch_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rotary_address_switch),
    .dout    (switch_stable)
  );

  // node address is taken once after reset, then held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_ff     <= 3'h0;
      addr_taken_ff <= 1'b0;
      node_addr_ff  <= 5'h00;
    end
    else if (!addr_taken_ff)
    begin
      if (settle_ff == `SRBB_SETTLE_CYCLES)
      begin
        node_addr_ff  <= switch_stable;
        addr_taken_ff <= 1'b1;
      end
      else
        settle_ff <= settle_ff + 3'h1;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      type_one_ff   <= `SRBB_TYPE_POSITION;
      type_two_ff   <= `SRBB_TYPE_SPEED;
      type_three_ff <= `SRBB_TYPE_TORQUE;
    end
    else
    begin
      type_one_ff   <= nxt_type_one;
      type_two_ff   <= nxt_type_two;
      type_three_ff <= nxt_type_three;
    end
  end

  assign mon_type_one   = type_one_ff;
  assign mon_type_two   = type_two_ff;
  assign mon_type_three = type_three_ff;

  // words two and three: result data unless the command is a normal one
  always @*
  begin
    if (cmd_ncyc_code == 4'h0)
    begin
      word_two   = mon_value_two;
      word_three = mon_value_three;
    end
    else
    begin
      word_two   = ncyc_result_two;
      word_three = ncyc_result_three;
    end
  end

  assign hdr_byte0 = {1'b1, cmd_update_counter, node_addr_ff};
  assign hdr_byte1 = {cmd_fault, cmd_code};

  // byte n sits at bits 8n+7..8n, so words go out low byte first
  assign blk16 = {word_three, word_two, mon_value_one,
                  input_flags, servo_flags, hdr_byte1, hdr_byte0};

  assign cmd_fire  = cmd_valid & cmd_ready;
  assign byte_fire = busy_ff & resp_ready;
  assign last_byte = (idx_ff == len_ff - 6'h01);
  assign cmd_ready = ~busy_ff & ctrl_ff[`SRBB_CTRL_ENABLE] & addr_taken_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift_ff     <= 256'h0;
      idx_ff       <= 6'h00;
      len_ff       <= `SRBB_SHORT_LEN;
      busy_ff      <= 1'b0;
      last_code_ff <= 7'h00;
      blk_count_ff <= 32'h0;
    end
    else if (cmd_fire)
    begin
      shift_ff     <= {128'h0, blk16};
      idx_ff       <= 6'h00;
      len_ff       <= ctrl_ff[`SRBB_CTRL_LONG] ? `SRBB_LONG_LEN : `SRBB_SHORT_LEN;
      busy_ff      <= 1'b1;
      last_code_ff <= cmd_code;
    end
    else if (byte_fire)
    begin
      shift_ff <= {8'h00, shift_ff[255:8]};
      idx_ff   <= idx_ff + 6'h01;
      if (last_byte)
      begin
        busy_ff      <= 1'b0;
        blk_count_ff <= blk_count_ff + 32'h1;
      end
    end
  end

  assign resp_valid = busy_ff;
  assign resp_data  = shift_ff[7:0];
  assign resp_last  = busy_ff & last_byte;

  // interrupt status: set wins over clear
  assign irq_events = {cmd_fire & cmd_fault, byte_fire & last_byte};

  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_ff <= 2'h0;
    else if (wr_fire && awaddr_ff == `SRBB_ADDR_IRQ_CLEAR && wstrb_ff[0])
      irq_status_ff <= (irq_status_ff & ~wdata_ff[1:0]) | irq_events;
    else
      irq_status_ff <= irq_status_ff | irq_events;
  end

  assign irq = |(irq_status_ff & irq_enable_ff);

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign wr_fire       = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wmask         = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                          {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SRBB_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        case (awaddr_ff)
          `SRBB_ADDR_CTRL,
          `SRBB_ADDR_MON_SEL,
          `SRBB_ADDR_IRQ_ENABLE,
          `SRBB_ADDR_IRQ_CLEAR,
          `SRBB_ADDR_STATUS,
          `SRBB_ADDR_IRQ_STATUS,
          `SRBB_ADDR_BLK_COUNT: bresp_ff <= `SRBB_RESP_OKAY;
          default:              bresp_ff <= `SRBB_RESP_SLVERR;
        endcase
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // writable registers; read-only ones ignore writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff       <= `SRBB_CTRL_RESET;
      mon_sel_ff    <= `SRBB_MON_SEL_RESET;
      irq_enable_ff <= 2'h0;
    end
    else if (wr_fire)
    begin
      case (awaddr_ff)
        `SRBB_ADDR_CTRL:
          if (wstrb_ff[0])
            ctrl_ff <= wdata_ff[1:0];
        `SRBB_ADDR_MON_SEL:
          mon_sel_ff <= (mon_sel_ff & ~wmask[23:0]) | (wdata_ff[23:0] & wmask[23:0]);
        `SRBB_ADDR_IRQ_ENABLE:
          if (wstrb_ff[0])
            irq_enable_ff <= wdata_ff[1:0];
        default:
          ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // read channel, one cycle after the address is taken
  assign s_axi_arready = ~rvalid_ff;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  always @*
  begin
    nxt_rdata = 32'h0;
    nxt_rresp = `SRBB_RESP_OKAY;
    case (s_axi_araddr)
      `SRBB_ADDR_CTRL:       nxt_rdata = {30'h0, ctrl_ff};
      `SRBB_ADDR_MON_SEL:    nxt_rdata = {8'h00, mon_sel_ff};
      `SRBB_ADDR_STATUS:
        nxt_rdata = {9'h000, last_code_ff, 6'h00, addr_taken_ff, busy_ff, 3'h0, node_addr_ff};
      `SRBB_ADDR_IRQ_STATUS: nxt_rdata = {30'h0, irq_status_ff};
      `SRBB_ADDR_IRQ_ENABLE: nxt_rdata = {30'h0, irq_enable_ff};
      `SRBB_ADDR_IRQ_CLEAR:  nxt_rdata = 32'h0;
      `SRBB_ADDR_BLK_COUNT:  nxt_rdata = blk_count_ff;
      default:               nxt_rresp = `SRBB_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `SRBB_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule // srbb_builder

// [logic/srbb_defines.vh]
`ifndef SRBB_DEFINES_VH
`define SRBB_DEFINES_VH

`define SRBB_ADDR_CTRL       8'h00
`define SRBB_ADDR_MON_SEL    8'h04
`define SRBB_ADDR_STATUS     8'h08
`define SRBB_ADDR_IRQ_STATUS 8'h0c
`define SRBB_ADDR_IRQ_ENABLE 8'h10
`define SRBB_ADDR_IRQ_CLEAR  8'h14
`define SRBB_ADDR_BLK_COUNT  8'h18

`define SRBB_CTRL_ENABLE     0
`define SRBB_CTRL_LONG       1
`define SRBB_CTRL_RESET      2'h1
`define SRBB_MON_SEL_RESET   24'h000000

`define SRBB_IRQ_SENT        0
`define SRBB_IRQ_FAULT       1

`define SRBB_TYPE_POSITION   8'h07
`define SRBB_TYPE_SPEED      8'h05
`define SRBB_TYPE_TORQUE     8'h06

`define SRBB_SHORT_LEN       6'h10
`define SRBB_LONG_LEN        6'h20
`define SRBB_SETTLE_CYCLES   3'h4

`define SRBB_RESP_OKAY       2'h0
`define SRBB_RESP_SLVERR     2'h2

`endif

// [logic/srbb_mon_sel.v]
`timescale 1ns/1ps
// maps a monitor select setting to the type code to fetch
module srbb_mon_sel #(
  parameter [7:0] DEFAULT_CODE = 8'h07
) (
  input  wire [7:0] sel,
  output wire [7:0] type_code
);

  assign type_code = (sel == 8'h00) ? DEFAULT_CODE : sel;

endmodule // srbb_mon_sel

// [logic/srbb_sync3.v]
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module srbb_sync3 #(
  parameter W = 5
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [W-1:0] out_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff  <= {W{1'b0}};
      s2_ff  <= {W{1'b0}};
      s3_ff  <= {W{1'b0}};
      out_ff <= {W{1'b0}};
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        out_ff <= s3_ff;
    end
  end

  assign dout = out_ff;

endmodule // srbb_sync3

// [tb/srbb_chk_assertions.sv]
`timescale 1ns/1ps
module srbb_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [1:0]  cmd_update_counter,
  input wire [6:0]  cmd_code,
  input wire        cmd_fault,
  input wire [3:0]  cmd_ncyc_code,
  input wire [31:0] ncyc_result_two,
  input wire [7:0]  servo_flags,
  input wire [7:0]  input_flags,
  input wire [7:0]  mon_type_one,
  input wire [7:0]  mon_type_two,
  input wire [7:0]  mon_type_three,
  input wire [31:0] mon_value_one,
  input wire [31:0] mon_value_two,
  input wire        resp_valid,
  input wire        resp_ready,
  input wire [7:0]  resp_data,
  input wire        resp_last
);
  reg [5:0] idx_ff;
  reg [1:0] upd_ff;
  reg [7:0] cap_ff [1:5];
  // byte position and the fields captured at accept
  always @(posedge aclk)
  begin
    if (!aresetn)
      idx_ff <= 6'h00;
    else if (resp_valid && resp_ready)
      idx_ff <= resp_last ? 6'h00 : idx_ff + 6'h01;
    if (cmd_valid && cmd_ready)
    begin
      upd_ff <= cmd_update_counter;
      cap_ff[1] <= {cmd_fault, cmd_code};
      cap_ff[2] <= servo_flags;
      cap_ff[3] <= input_flags;
      cap_ff[4] <= mon_value_one[7:0];
      cap_ff[5] <= (cmd_ncyc_code == 4'h0) ? mon_value_two[7:0] : ncyc_result_two[7:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hdr;
    resp_valid && idx_ff == 6'h00 |-> resp_data[7:5] == {1'b1, upd_ff};
  endproperty
  a_hdr: assert property (p_hdr) else $error("byte 0 header wrong");
  property p_byte;
    resp_valid && idx_ff >= 6'h01 && idx_ff <= 6'h03 |-> resp_data == cap_ff[idx_ff];
  endproperty
  a_byte: assert property (p_byte) else $error("byte 1-3 wrong");
  property p_w1;
    resp_valid && idx_ff == 6'h04 |-> resp_data == cap_ff[4];
  endproperty
  a_w1: assert property (p_w1) else $error("word one low byte wrong");
  property p_w2;
    resp_valid && idx_ff == 6'h08 |-> resp_data == cap_ff[5];
  endproperty
  a_w2: assert property (p_w2) else $error("word two low byte wrong");
  property p_last;
    resp_last |-> resp_valid && (idx_ff == 6'h0f || idx_ff == 6'h1f);
  endproperty
  a_last: assert property (p_last) else $error("block length wrong");
  property p_zero;
    resp_valid && idx_ff[4] |-> resp_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("unused byte not zero");
  property p_hold;
    resp_valid && !resp_ready |=> resp_valid && $stable(resp_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost while stalled");
  property p_rst;
    $rose(aresetn) |-> {mon_type_one, mon_type_two, mon_type_three} == 24'h070506;
  endproperty
  a_rst: assert property (p_rst) else $error("default monitor types wrong");
  c_long: cover property (resp_last && idx_ff == 6'h1f);
  c_fault: cover property (cmd_valid && cmd_ready && cmd_fault);
  c_stall: cover property (resp_valid && !resp_ready);
endmodule // srbb_chk

bind srbb_builder srbb_chk u_srbb_chk (.*);

// [tb/srbb_host_model.sv]
`timescale 1ns/1ps
module srbb_host_model (
  input  wire       aclk,
  input  wire       cmd_ready,
  input  wire       resp_valid,
  input  wire [7:0] resp_data,
  input  wire       resp_last,
  output reg        cmd_valid,
  output reg  [1:0] cmd_update_counter,
  output reg  [6:0] cmd_code,
  output reg        cmd_fault,
  output reg  [3:0] cmd_ncyc_code,
  output reg        resp_ready
);
  reg     [7:0] blk [0:31];
  integer       n;
  initial
    {cmd_valid, cmd_update_counter, cmd_code, cmd_fault, cmd_ncyc_code, resp_ready} = 16'h0;
  // one command, then collect the block; st makes the sink stall every other cycle
  task send(input [1:0] u, input [6:0] c, input f, input [3:0] nc, input st);
    integer k;
    begin
      @(posedge aclk);
      {cmd_update_counter, cmd_code, cmd_fault, cmd_ncyc_code} <= {u, c, f, nc};
      cmd_valid <= 1'b1;
      resp_ready <= 1'b1;
      n = 0;
      k = 0;
      do @(posedge aclk); while (!cmd_ready);
      cmd_valid <= 1'b0;
      // released fields carry no valid data
      {cmd_update_counter, cmd_code, cmd_fault, cmd_ncyc_code} <= ~{u, c, f, nc};
      while (k == 0)
      begin
        @(posedge aclk);
        if (resp_valid && resp_ready)
        begin
          blk[n] = resp_data;
          n = n + 1;
          k = resp_last;
        end
        resp_ready <= st ? ~resp_ready : 1'b1;
      end
    end
  endtask
endmodule // srbb_host_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  reg         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg  [4:0]  rotary_address_switch = 5'h13;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [7:0]  servo_flags = 8'ha5, input_flags = 8'h5a;
  reg  [31:0] s_axi_wdata = 32'h0, ncyc_result_two = 32'hc3b2a190;
  reg  [31:0] ncyc_result_three = 32'h0f1e2d3c, mon_value_one = 32'h44332211;
  reg  [31:0] mon_value_two = 32'h88776655, mon_value_three = 32'hccbbaa99;
  reg  [31:0] d;
  reg  [1:0]  r;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, cmd_update_counter;
  wire [31:0] s_axi_rdata;
  wire        cmd_valid, cmd_ready, cmd_fault, resp_valid, resp_ready, resp_last, irq;
  wire [6:0]  cmd_code;
  wire [3:0]  cmd_ncyc_code;
  wire [7:0]  mon_type_one, mon_type_two, mon_type_three, resp_data;
  integer     miscompares = 0, samples_checked = 0, cyc = 0;
  srbb_builder u_srbb_builder (.*);
  srbb_host_model u_srbb_host_model (.*);
  always #50 aclk = ~aclk;
  task complete_run;
    begin
      if (miscompares == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  task chk(input string nm, input [31:0] s, input [31:0] x);
    begin
      samples_checked = samples_checked + 1;
      if (s !== x)
      begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    reg pa, pw;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
        @(posedge aclk);
        if (s_axi_awready)
          pa = 1'b0;
        if (s_axi_wready)
          pw = 1'b0;
        s_axi_awvalid <= pa;
        s_axi_wvalid <= pw;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // one block through the host model, compared byte by byte
  task run(input [1:0] u, input [6:0] c, input f, input [3:0] nc, input st, input lg);
    reg [255:0] e;
    integer     i;
    begin
      e = {128'h0, nc == 4'h0 ? {mon_value_three, mon_value_two}
           : {ncyc_result_three, ncyc_result_two}, mon_value_one, input_flags,
           servo_flags, f, c, 1'b1, u, 5'h13};
      u_srbb_host_model.send(u, c, f, nc, st);
      chk("length", u_srbb_host_model.n, lg ? 32 : 16);
      for (i = 0; i < (lg ? 32 : 16); i = i + 1)
        chk("byte", u_srbb_host_model.blk[i], e[8*i+:8]);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("cmd_ready", cmd_ready, 32'h0);
    repeat (7) @(posedge aclk);
    rotary_address_switch <= 5'h0a;
    chk("types", {mon_type_one, mon_type_two, mon_type_three}, 24'h070506);
    wr(8'h04, 32'h00332211);
    chk("bresp", r, 32'h0);
    repeat (2) @(posedge aclk);
    chk("types", {mon_type_three, mon_type_two, mon_type_one}, 24'h332211);
    s_axi_wstrb <= 4'h2;
    wr(8'h04, 32'h00ffffff);
    repeat (2) @(posedge aclk);
    chk("types", {mon_type_three, mon_type_two, mon_type_one}, 24'h33ff11);
    s_axi_wstrb <= 4'hf;
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h1);
    run(2'h2, 7'h15, 1'b0, 4'h0, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 32'h1);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 32'h0);
    wr(8'h00, 32'h3);
    run(2'h1, 7'h7f, 1'b1, 4'h3, 1'b0, 1'b1);
    run(2'h3, 7'h00, 1'b0, 4'h0, 1'b0, 1'b1);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 32'h0);
    rd(8'h0c);
    chk("irq_status", d, 32'h3);
    rd(8'h18);
    chk("blk_count", d, 32'h3);
    rd(8'h08);
    chk("status", d, 32'h00000213);
    wr(8'h40, 32'h1);
    chk("bresp", r, 32'h2);
    rd(8'h40);
    chk("unmapped", {d[29:0], r}, 32'h2);
    complete_run;
  end
endmodule // tb
